// >>> inc/cgr_defines.svh
// Constants for the custom glyph address resolver.
// Assumes inclusion by bare name from the rtl files.
`ifndef CGR_DEFINES_SVH
`define CGR_DEFINES_SVH
`define CGR_CODE_MASK 16'h7FFF
`define CGR_FULL_BIT 15
`define CGR_SIZE_SMALL 2'h0
`define CGR_SIZE_MID 2'h1
`define CGR_SIZE_LARGE 2'h2
`define CGR_BYTES_8X16 8'h10
`define CGR_BYTES_12X24 8'h30
`define CGR_BYTES_16X32 8'h40
`define CGR_BYTES_16X16 8'h20
`define CGR_BYTES_24X24 8'h48
`define CGR_BYTES_32X32 8'h80
`define CGR_ROW_1 3'h1
`define CGR_ROW_2 3'h2
`define CGR_ROW_3 3'h3
`define CGR_ROW_4 3'h4
`define CGR_ODD_IGNORE 8'hF0
`define CGR_BITS_BYTE 4'h8
`define CGR_BITS_NIBBLE 4'h4
`endif

// >>> inc/cgr_pkg.sv
// Types for the custom glyph address resolver.
// Assumes nothing beyond the defines header.
package cgr_pkg;
  typedef enum logic [1:0] {
    CGR_IDLE = 2'b00,
    CGR_HIGH = 2'b01,
    CGR_READ = 2'b10,
    CGR_WAIT = 2'b11
  } cgr_state_e;
  typedef struct packed {
    logic [23:0] fg;
    logic [23:0] bg;
  } cgr_colour_s;
  typedef struct packed {
    logic valid;
    logic [23:0] colour;
    logic last;
  } cgr_pixel_s;
endpackage

// >>> rtl/cgr_resolver.sv
// Custom glyph resolver: takes a 16-bit glyph code in two host bytes,
// reads the bitmap from glyph RAM and streams coloured pixels out.
// Assumes a glyph RAM with one-cycle read latency and a pixel sink
// that accepts one pixel per clock.
// Operation
// RQ1 - Codes below 8000h half, above full width
// RQ2 - Three half and three full glyph sizes
// RQ3 - Host sends code upper byte first
// RQ4 - Complete code converted, bitmap copied to buffer
// RQ5 - Pixels painted in foreground and background colours
// RQ6 - Both widths share one glyph base
// RQ7 - 8*16: sixteen bytes, base plus code*16
// RQ8 - Successive codes occupy back-to-back blocks
// RQ9 - 16*16: thirty-two bytes, two per row
// RQ10 - 12*24: forty-eight bytes, base plus code*48
// RQ11 - 12*24: odd bytes low nibble ignored
// RQ12 - 24*24: seventy-two bytes, three per row
// RQ13 - 16*32: sixty-four bytes, two per row
// RQ14 - 32*32: 128 bytes, four per row
// RQ15 - Byte MSB is leftmost pixel
// RQ16 - Code masked to 15 bits always
`timescale 1ns/1ps
`include "cgr_defines.svh"

module cgr_resolver #(
  parameter int ADDR_W = 24
) (
  input wire logic i_ref_clk,                 // 40 MHz system clock
  input wire logic i_nrst,                    // Async reset, active low
  input wire logic i_code_we,                 // Host byte strobe
  input wire logic [7:0] i_code_byte,         // Host code byte
  input wire logic [1:0] i_glyph_size,        // Size select per width
  input wire logic [ADDR_W-1:0] i_glyph_base_address, // Glyph region base
  input wire cgr_pkg::cgr_colour_s i_colour,  // Foreground and background
  input wire logic [7:0] i_ram_data,          // Glyph RAM read data
  output logic o_ram_re,                      // Glyph RAM read strobe
  output logic [ADDR_W-1:0] o_ram_addr,       // Glyph RAM address
  output cgr_pkg::cgr_pixel_s o_pixel,        // Pixel to display buffer
  output logic o_busy                         // Glyph in progress
);

  cgr_pkg::cgr_state_e state, next_state;
  logic [7:0] code_high, next_code_high;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [7:0] remain, next_remain;
  logic odd_ignore, next_odd_ignore;
  logic [7:0] shift, next_shift;
  logic [3:0] bits_left, next_bits_left;
  logic last_byte, next_last_byte;
  logic ram_re, next_ram_re;
  logic ram_valid, next_ram_valid;
  logic [ADDR_W-1:0] ram_addr, next_ram_addr;
  logic busy, next_busy;
  cgr_pkg::cgr_pixel_s pixel, next_pixel;
  logic [14:0] code_idx;
  logic [7:0] glyph_bytes;
  logic is_full;
  logic [ADDR_W-1:0] start_addr;

  // Width from code MSB, byte count from size and width
  always_comb
  begin
    code_idx = 15'({code_high, i_code_byte} & `CGR_CODE_MASK); // RQ16
    is_full = code_high[7]; // RQ1
    glyph_bytes = `CGR_BYTES_8X16; // RQ2
    case (i_glyph_size)
      `CGR_SIZE_SMALL: glyph_bytes = is_full ? `CGR_BYTES_16X16 : `CGR_BYTES_8X16; // RQ7 RQ9
      `CGR_SIZE_MID: glyph_bytes = is_full ? `CGR_BYTES_24X24 : `CGR_BYTES_12X24; // RQ10 RQ12
      `CGR_SIZE_LARGE: glyph_bytes = is_full ? `CGR_BYTES_32X32 : `CGR_BYTES_16X32; // RQ13 RQ14
      default: glyph_bytes = `CGR_BYTES_8X16;
    endcase
    // Same base for both widths; blocks laid back to back
    start_addr = ADDR_W'(i_glyph_base_address +
      ADDR_W'(code_idx) * ADDR_W'(glyph_bytes)); // RQ6 RQ8
  end

  // Control path
  always_comb
  begin
    next_state = state;
    next_code_high = code_high;
    next_addr = addr;
    next_remain = remain;
    next_odd_ignore = odd_ignore;
    next_ram_re = 1'b0;
    next_ram_addr = ram_addr;
    case (state)
      cgr_pkg::CGR_IDLE:
      begin
        if (i_code_we)
        begin
          next_code_high = i_code_byte; // RQ3
          next_state = cgr_pkg::CGR_HIGH;
        end
      end
      cgr_pkg::CGR_HIGH:
      begin
        if (i_code_we)
        begin
          next_addr = start_addr; // RQ4
          next_remain = glyph_bytes;
          next_odd_ignore = !is_full && (i_glyph_size == `CGR_SIZE_MID);
          next_state = cgr_pkg::CGR_READ;
        end
      end
      cgr_pkg::CGR_READ:
      begin
        // Issue a read only once the previous byte is nearly drained
        // and no fetch is still in flight through the one-cycle RAM
        if (bits_left <= 4'h1 && !ram_re && !ram_valid)
        begin
          next_ram_re = 1'b1;
          next_ram_addr = addr;
          next_addr = addr + ADDR_W'(1);
          next_remain = remain - 8'h01;
          if (remain == 8'h01)
            next_state = cgr_pkg::CGR_WAIT;
        end
      end
      cgr_pkg::CGR_WAIT:
      begin
        if (!ram_re && !ram_valid && bits_left == 4'h0 && !last_byte)
          next_state = cgr_pkg::CGR_IDLE;
      end
      default: next_state = cgr_pkg::CGR_IDLE;
    endcase
    // Registered so the busy output comes straight from a flop
    next_busy = (next_state == cgr_pkg::CGR_READ) || (next_state == cgr_pkg::CGR_WAIT);
  end

  // Pixel path: one bit per clock, MSB first
  always_comb
  begin
    next_shift = shift;
    next_bits_left = bits_left;
    next_last_byte = last_byte;
    next_pixel = '0;
    next_ram_valid = ram_re;
    if (ram_valid)
    begin
      next_shift = i_ram_data;
      // Odd byte of 12-dot rows carries only four pixels; byte count is
      // even, so remain is even exactly on odd bytes, whatever the base
      next_bits_left = (odd_ignore && remain[0] == 1'b0) ?
        `CGR_BITS_NIBBLE : `CGR_BITS_BYTE; // RQ11
      next_last_byte = (state == cgr_pkg::CGR_WAIT);
    end
    if (bits_left != 4'h0)
    begin
      next_pixel.valid = 1'b1;
      next_pixel.colour = shift[7] ? i_colour.fg : i_colour.bg; // RQ5 RQ15
      next_pixel.last = last_byte && bits_left == 4'h1;
      if (!ram_valid)
      begin
        next_shift = {shift[6:0], 1'b0};
        next_bits_left = bits_left - 4'h1;
        if (bits_left == 4'h1)
          next_last_byte = 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= cgr_pkg::CGR_IDLE;
      code_high <= 8'h00;
      addr <= '0;
      remain <= 8'h00;
      odd_ignore <= 1'b0;
      shift <= 8'h00;
      bits_left <= 4'h0;
      last_byte <= 1'b0;
      ram_re <= 1'b0;
      ram_valid <= 1'b0;
      ram_addr <= '0;
      busy <= 1'b0;
      pixel <= '0;
    end
    else
    begin
      state <= next_state;
      code_high <= next_code_high;
      addr <= next_addr;
      remain <= next_remain;
      odd_ignore <= next_odd_ignore;
      shift <= next_shift;
      bits_left <= next_bits_left;
      last_byte <= next_last_byte;
      ram_re <= next_ram_re;
      ram_valid <= next_ram_valid;
      ram_addr <= next_ram_addr;
      busy <= next_busy;
      pixel <= next_pixel;
    end
  end

  assign o_ram_re = ram_re;
  assign o_ram_addr = ram_addr;
  assign o_pixel = pixel;
  assign o_busy = busy;

  property p_start_addr;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == cgr_pkg::CGR_HIGH && i_code_we) |=>
      addr == $past(start_addr);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("bad glyph start"); // RQ4

  property p_mask;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == cgr_pkg::CGR_HIGH && i_code_we && i_glyph_size == `CGR_SIZE_SMALL && !is_full)
      |=> addr == $past(i_glyph_base_address) +
        ADDR_W'($past(code_idx)) * ADDR_W'(`CGR_BYTES_8X16);
  endproperty
  a_mask: assert property (p_mask) else $error("8x16 address wrong"); // RQ7

  property p_high_first;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == cgr_pkg::CGR_IDLE && i_code_we) |=> code_high == $past(i_code_byte);
  endproperty
  a_high_first: assert property (p_high_first) else $error("upper byte lost"); // RQ3

  property p_colour;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (bits_left != 4'h0) |=> o_pixel.valid &&
      o_pixel.colour == ($past(shift[7]) ? $past(i_colour.fg) : $past(i_colour.bg));
  endproperty
  a_colour: assert property (p_colour) else $error("pixel colour wrong"); // RQ5

  property p_byte_step;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ram_re ##1 ram_re |-> 1'b0;
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("reads back to back"); // RQ4

  property p_nibble;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (ram_valid && odd_ignore && remain[0] == 1'b0) |=> bits_left == `CGR_BITS_NIBBLE;
  endproperty
  a_nibble: assert property (p_nibble) else $error("odd byte nibble used"); // RQ11

  property p_count;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == cgr_pkg::CGR_HIGH && i_code_we && is_full && i_glyph_size == `CGR_SIZE_LARGE)
      |=> remain == `CGR_BYTES_32X32;
  endproperty
  a_count: assert property (p_count) else $error("32x32 count wrong"); // RQ14

  property p_count24;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == cgr_pkg::CGR_HIGH && i_code_we && is_full && i_glyph_size == `CGR_SIZE_MID)
      |=> remain == `CGR_BYTES_24X24;
  endproperty
  a_count24: assert property (p_count24) else $error("24x24 count wrong"); // RQ12

  property p_count16;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == cgr_pkg::CGR_HIGH && i_code_we && is_full && i_glyph_size == `CGR_SIZE_SMALL)
      |=> remain == `CGR_BYTES_16X16;
  endproperty
  a_count16: assert property (p_count16) else $error("16x16 count wrong"); // RQ9

  property p_count48;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == cgr_pkg::CGR_HIGH && i_code_we && !is_full && i_glyph_size == `CGR_SIZE_MID)
      |=> remain == `CGR_BYTES_12X24;
  endproperty
  a_count48: assert property (p_count48) else $error("12x24 count wrong"); // RQ10

  property p_count64;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == cgr_pkg::CGR_HIGH && i_code_we && !is_full && i_glyph_size == `CGR_SIZE_LARGE)
      |=> remain == `CGR_BYTES_16X32;
  endproperty
  a_count64: assert property (p_count64) else $error("16x32 count wrong"); // RQ13

  property p_addr_step;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ram_re |-> addr == ram_addr + ADDR_W'(1);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("read address skipped"); // RQ8

  property p_read_gap;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    ram_re |=> !ram_re ##1 !ram_re;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("read during fetch"); // RQ4

  property p_busy;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    o_busy == ((state == cgr_pkg::CGR_READ) || (state == cgr_pkg::CGR_WAIT));
  endproperty
  a_busy: assert property (p_busy) else $error("busy out of step"); // RQ4

  property p_last_end;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    o_pixel.last |=> !o_pixel.valid;
  endproperty
  a_last_end: assert property (p_last_end) else $error("pixel after last"); // RQ4

  property p_full_base;
    @(posedge i_ref_clk) disable iff (!i_nrst)
    (state == cgr_pkg::CGR_HIGH && i_code_we && is_full && code_idx == 15'h0000)
      |=> addr == $past(i_glyph_base_address);
  endproperty
  a_full_base: assert property (p_full_base) else $error("full base wrong"); // RQ6

  c_full: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == cgr_pkg::CGR_HIGH && i_code_we && is_full);
  c_half_mid: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == cgr_pkg::CGR_HIGH && i_code_we && !is_full && i_glyph_size == `CGR_SIZE_MID);
  c_last: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) o_pixel.last);
  c_half_large: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == cgr_pkg::CGR_HIGH && i_code_we && !is_full && i_glyph_size == `CGR_SIZE_LARGE);
  c_refused: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_busy && i_code_we);

endmodule

// >>> tb/cgr_host_model.sv
// Host side model: writes 16-bit glyph codes as two byte strobes.
// Assumes the resolver samples bytes on the rising clock edge.
`timescale 1ns/1ps

module cgr_host_model (
  input wire logic i_ref_clk,     // System clock
  output logic o_code_we,         // Byte strobe
  output logic [7:0] o_code_byte  // Code byte
);
  initial
  begin
    o_code_we = 1'b0;
    o_code_byte = 8'hA5;
  end

  task automatic send(input logic [15:0] code);
    @(posedge i_ref_clk);
    #2;
    o_code_we = 1'b1;
    o_code_byte = code[15:8];
    @(posedge i_ref_clk);
    #2;
    o_code_byte = code[7:0];
    @(posedge i_ref_clk);
    #2;
    o_code_we = 1'b0;
    // Released bus shows no stale byte
    o_code_byte = ~code[7:0];
  endtask
endmodule

// >>> tb/cgr_resolver_bench.sv
// Bench for the glyph resolver, with glyph RAM and host models.
// Assumes one-cycle RAM latency and one code at a time.
`timescale 1ns/1ps

module cgr_resolver_bench;
  localparam int AW = 24;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_code_we;
  logic [7:0] i_code_byte;
  logic [1:0] i_glyph_size = 2'h0;
  logic [AW-1:0] i_glyph_base_address = 24'h001000;
  cgr_pkg::cgr_colour_s i_colour = {24'hFF0000, 24'h0000FF};
  logic [7:0] i_ram_data = 8'h00;
  logic o_ram_re;
  logic [AW-1:0] o_ram_addr;
  cgr_pkg::cgr_pixel_s o_pixel;
  logic o_busy;
  int error_cnt = 0;
  int check_count = 0;
  int rd_cnt, pix_cnt, npx, lo;
  logic [AW-1:0] exp_addr;
  logic [7:0] d;
  logic half12, saw_busy, bit_v;
  logic q[$];

  always #12.5 i_ref_clk = ~i_ref_clk;

  cgr_host_model cgr_host_model_i (.i_ref_clk(i_ref_clk), .o_code_we(i_code_we),
    .o_code_byte(i_code_byte));
  cgr_resolver #(.ADDR_W(AW)) cgr_resolver_i (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_code_we(i_code_we), .i_code_byte(i_code_byte), .i_glyph_size(i_glyph_size),
    .i_glyph_base_address(i_glyph_base_address), .i_colour(i_colour),
    .i_ram_data(i_ram_data), .o_ram_re(o_ram_re), .o_ram_addr(o_ram_addr),
    .o_pixel(o_pixel), .o_busy(o_busy));

  // Idle cycles toggle the data so stale bytes are never mistaken
  always @(posedge i_ref_clk)
    i_ram_data <= (o_ram_re === 1'b1) ? (o_ram_addr[7:0] ^ 8'h5A) : ~i_ram_data;

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("FAIL t=%0t %s", $time, m);
    end
  endtask

  always @(posedge i_ref_clk)
  begin
    if (o_busy === 1'b1)
      saw_busy = 1'b1;
    if (o_ram_re === 1'b1)
    begin
      chk(o_ram_addr === exp_addr + AW'(rd_cnt), "read address");
      d = o_ram_addr[7:0] ^ 8'h5A;
      lo = (half12 && rd_cnt[0]) ? 4 : 0;
      for (int b = 7; b >= lo; b--)
        q.push_back(d[b]);
      rd_cnt++;
    end
    if (o_pixel.valid === 1'b1)
    begin
      bit_v = (q.size() > 0) ? q.pop_front() : 1'bx;
      chk(o_pixel.colour === (bit_v ? i_colour.fg : i_colour.bg), "pixel colour");
      chk(o_pixel.last === (pix_cnt == npx - 1), "last flag");
      pix_cnt++;
    end
  end

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Poke sends a stray code mid-glyph, which must be ignored
  task automatic glyph(input logic [1:0] sz, input logic [15:0] code, input int nb,
    input bit poke);
    int k;
    i_glyph_size = sz;
    half12 = (sz == 2'h1) && !code[15];
    npx = half12 ? nb * 6 : nb * 8;
    exp_addr = i_glyph_base_address + AW'(int'(code[14:0]) * nb);
    rd_cnt = 0;
    pix_cnt = 0;
    saw_busy = 1'b0;
    q.delete();
    cgr_host_model_i.send(code);
    if (poke)
    begin
      repeat (6) @(posedge i_ref_clk);
      cgr_host_model_i.send(16'h0123);
    end
    k = 0;
    while (pix_cnt < npx && k < 3000)
    begin
      @(posedge i_ref_clk);
      #2;
      k++;
    end
    if (k >= 3000)
    begin
      error_cnt++;
      $display("FAIL t=%0t glyph timeout", $time);
      close_out();
    end
    repeat (4) @(posedge i_ref_clk);
    #2;
    chk(saw_busy && o_busy === 1'b0 && rd_cnt == nb && q.size() == 0, "glyph length");
  endtask

  task automatic s_half();
    glyph(2'h0, 16'h0001, 16, 0);
    glyph(2'h1, 16'h0001, 48, 0);
    glyph(2'h2, 16'h0001, 64, 0);
  endtask

  task automatic s_full();
    glyph(2'h0, 16'h8001, 32, 0);
    glyph(2'h1, 16'h8000, 72, 0);
    glyph(2'h2, 16'h8001, 128, 0);
  endtask

  task automatic s_mask();
    glyph(2'h2, 16'h7FFF, 64, 0);
    glyph(2'h0, 16'hFFFF, 32, 0);
    glyph(2'h3, 16'h0002, 16, 0);
  endtask

  task automatic s_colour_refused();
    i_colour = {24'h12AB34, 24'hC0FFEE};
    glyph(2'h0, 16'h0003, 16, 1);
  endtask

  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    chk(o_busy === 1'b0 && o_ram_re === 1'b0 && o_pixel.valid === 1'b0, "reset");
    #2;
    i_nrst = 1'b1;
    s_half();
    s_full();
    s_mask();
    s_colour_refused();
    close_out();
  end
endmodule
